// >>> src/sup_pkg.sv
// sup_pkg: shared constants and carrier types for the supervisor block
// assumes a 200 MHz system clock; the power-fail level is an input
package sup_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned HOLD_MS = 250;
   localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
   localparam int unsigned DEB_US = 10;
   localparam int unsigned DEB_CYC = (CLK_HZ / 1_000_000) * DEB_US;
   localparam int unsigned WDOG_MS = 1600;
   localparam int unsigned WDOG_CYC = (CLK_HZ / 1000) * WDOG_MS;
   localparam int unsigned CNT_W = 32;

   typedef struct packed {
      logic ram_select_in_n;
      logic upper_byte_select_n;
      logic lower_byte_select_n;
   } sup_ram_in_t;

   typedef struct packed {
      logic ram_high_select_n;
      logic ram_low_select_n;
   } sup_ram_out_t;

   typedef enum logic [2:0] {
      S_RUN = 3'h1,
      S_DEB = 3'h2,
      S_HOLD = 3'h4
   } sup_state_t;
endpackage : sup_pkg

// >>> src/sup_timer.sv
// sup_timer: restartable cycle counter that flags when a limit is reached
// assumes restart and run are synchronous to i_clk
`timescale 1ns/1ps
module sup_timer
   import sup_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // control
   input wire logic i_restart,
   input wire logic i_run,
   input wire logic [CNT_W-1:0] i_limit,
   // status
   output logic o_done
);
   logic [CNT_W-1:0] cnt_q;
   wire at_limit = (cnt_q >= i_limit);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= '0;
      end else if (i_ce) begin
         if (i_restart) begin
            cnt_q <= '0;
         end else if (i_run && !at_limit) begin
            cnt_q <= cnt_q + CNT_W'(1);
         end
      end
   end

   assign o_done = at_limit;
endmodule : sup_timer

// >>> src/sup_top.sv
// sup_top: processor supervisor with reset generation and sram select gating
// assumes i_supply_ok comes from an external comparator, synchronous to i_clk;
// the reset pin is open drain with an outside pullup
//
// How it works
// - reset low on fail, watchdog, hold, button
// - debounced button gives at least 250ms reset
// - missed watchdog kick forces reset
// - wait 250ms hold after supply rises
// - inputs ignored during power-up hold
// - reset held 250ms after supply returns
// - high select needs upper byte and select low
// - low select needs lower byte and select low
// - supply fail forces both selects high
// - selects inactive until hold time ends
`timescale 1ns/1ps
module sup_top
   import sup_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = HOLD_CYC,
   parameter int unsigned DEB_CYCLES = DEB_CYC,
   parameter int unsigned WDOG_CYCLES = WDOG_CYC
) (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // supply comparator, high while above power_fail_level
   input wire logic i_supply_ok,
   // host strobes
   input wire logic i_watchdog_kick_n,
   input wire sup_ram_in_t i_ram,
   // open-drain reset pin
   input wire logic i_rst_pin_n,
   output logic o_rst_pin_n,
   output logic o_rst_pin_oe,
   // sram selects
   output sup_ram_out_t o_ram
);
   sup_state_t state_q, state_d;
   logic ready_q;
   logic kick_prev_q;
   logic rst_oe_q;
   sup_ram_out_t ram_q;

   logic hold_done, deb_done, wdog_done, btn_done;

   // power-up hold timer restarts whenever the supply drops
   sup_timer u_hold (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_restart(!i_supply_ok),
      .i_run(1'b1),
      .i_limit(CNT_W'(HOLD_CYCLES)),
      .o_done(hold_done)
   );

   wire inputs_live = i_supply_ok && ready_q;
   wire kick_fall = inputs_live && kick_prev_q && !i_watchdog_kick_n;
   // pin reads low while we drive it, so only a low seen while released counts
   wire btn_low = inputs_live && !rst_oe_q && !i_rst_pin_n;

   // watchdog restarted by each kick edge, also by any reset pulse
   sup_timer u_wdog (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_restart(kick_fall || !inputs_live || state_q != S_RUN),
      .i_run(1'b1),
      .i_limit(CNT_W'(WDOG_CYCLES)),
      .o_done(wdog_done)
   );

   // debounce: the low must persist this long before a reset pulse
   sup_timer u_deb (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_restart(!(btn_low && state_q == S_DEB)),
      .i_run(1'b1),
      .i_limit(CNT_W'(DEB_CYCLES)),
      .o_done(deb_done)
   );

   // reset pulse width timer for button and watchdog
   sup_timer u_pulse (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_restart(state_q != S_HOLD),
      .i_run(1'b1),
      .i_limit(CNT_W'(HOLD_CYCLES)),
      .o_done(btn_done)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         S_RUN: begin
            if (wdog_done) begin
               state_d = S_HOLD;
            end else if (btn_low) begin
               state_d = S_DEB;
            end
         end
         S_DEB: begin
            if (!btn_low) begin
               state_d = S_RUN;
            end else if (deb_done) begin
               state_d = S_HOLD;
            end
         end
         S_HOLD: begin
            if (btn_done) begin
               state_d = S_RUN;
            end
         end
         default: state_d = S_RUN;
      endcase
   end

   wire rst_req = !i_supply_ok || !ready_q || state_q == S_HOLD;
   wire ram_en = i_supply_ok && ready_q;
   wire high_sel_n = !(ram_en && !i_ram.ram_select_in_n
                       && !i_ram.upper_byte_select_n);
   wire low_sel_n = !(ram_en && !i_ram.ram_select_in_n
                      && !i_ram.lower_byte_select_n);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= S_RUN;
         ready_q <= 1'b0;
         kick_prev_q <= 1'b1;
         rst_oe_q <= 1'b1;
         ram_q <= '1;
      end else if (i_ce) begin
         state_q <= inputs_live ? state_d : S_RUN;
         ready_q <= i_supply_ok && hold_done;
         kick_prev_q <= i_watchdog_kick_n;
         rst_oe_q <= rst_req;
         ram_q <= '{ram_high_select_n: high_sel_n, ram_low_select_n: low_sel_n};
      end
   end

   assign o_rst_pin_oe = rst_oe_q;
   assign o_rst_pin_n = 1'b0;
   assign o_ram = ram_q;

   // assertion helpers: run lengths of the reset pulse and of the button low
   logic [CNT_W-1:0] oe_run_q, oe_run_d;
   logic [CNT_W-1:0] btn_run_q, btn_run_d;
   // saturate so a very long run cannot wrap and look short
   assign oe_run_d = !rst_oe_q ? '0 : (&oe_run_q) ? oe_run_q : oe_run_q + CNT_W'(1);
   assign btn_run_d = !btn_low ? '0 : (&btn_run_q) ? btn_run_q : btn_run_q + CNT_W'(1);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         oe_run_q <= '0;
         btn_run_q <= '0;
      end else if (i_ce) begin
         oe_run_q <= oe_run_d;
         btn_run_q <= btn_run_d;
      end
   end

   // assertions
   a_fail_resets: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && !i_supply_ok) |=> o_rst_pin_oe)
      else $error("reset not driven during supply fail");
   a_fail_blocks_ram: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && !i_supply_ok) |=> (o_ram == '1))
      else $error("sram select active during supply fail");
   a_hold_blocks_ram: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && !ready_q) |=> (o_ram == '1))
      else $error("sram select active before hold ends");
   a_high_select: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && ram_en && !i_ram.ram_select_in_n && !i_ram.upper_byte_select_n)
      |=> !o_ram.ram_high_select_n)
      else $error("high select not asserted");
   a_high_blocked: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && (i_ram.ram_select_in_n || i_ram.upper_byte_select_n))
      |=> o_ram.ram_high_select_n)
      else $error("high select asserted without both strobes");
   a_low_select: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && (i_ram.ram_select_in_n || i_ram.lower_byte_select_n))
      |=> o_ram.ram_low_select_n)
      else $error("low select asserted without both strobes");
   a_low_asserted: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && ram_en && !i_ram.ram_select_in_n && !i_ram.lower_byte_select_n)
      |=> !o_ram.ram_low_select_n)
      else $error("low select not asserted");
   a_ready_needs_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      $rose(ready_q) |-> $past(hold_done) && $past(i_supply_ok))
      else $error("ready before hold time");
   a_no_early_release: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && !ready_q) |=> o_rst_pin_oe)
      else $error("reset released before hold ends");
   a_inputs_ignored: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && !ready_q) |=> (state_q == S_RUN))
      else $error("input acted on during hold");
   a_kick_ignored: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && !inputs_live) |=> !wdog_done)
      else $error("watchdog ran while inputs disabled");
   a_supply_return: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && $past(i_ce) && $rose(i_supply_ok)) |-> o_rst_pin_oe)
      else $error("reset not held as supply returns");
   a_oe_on_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && state_q == S_HOLD) |=> o_rst_pin_oe)
      else $error("reset not driven during pulse");
   a_wdog_reset: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && inputs_live && state_q == S_RUN && wdog_done) |=> ##1 o_rst_pin_oe)
      else $error("watchdog expiry gave no reset");
   a_kick_restarts: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && kick_fall && state_q == S_RUN) |=> !wdog_done)
      else $error("kick did not restart watchdog");
   a_deb_needs_low: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && state_q == S_DEB && !btn_low) |=> (state_q == S_RUN))
      else $error("debounce kept after button released");
   a_debounce_len: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && state_q == S_DEB && btn_low && deb_done) |-> (btn_run_q >= CNT_W'(DEB_CYCLES)))
      else $error("button pulse shorter than debounce time");
   // every reset pulse, whatever its cause, lasts at least the hold time
   a_button_width: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      $fell(o_rst_pin_oe) |-> (oe_run_q >= CNT_W'(HOLD_CYCLES)))
      else $error("reset pulse released early");
endmodule : sup_top

// >>> verif/sup_host.sv
// sup_host: host side of the reset wire and the watchdog kicker
// assumes a pullup on the wire; kicks only while i_kick_en is high
`timescale 1ns/1ps
module sup_host (
   // clock
   input wire logic i_clk,
   // wire parties and control
   input wire logic i_oe,
   input wire logic i_data_n,
   input wire logic i_button_n,
   input wire logic i_kick_en,
   // resolved wire and strobe
   output logic o_pin_n,
   output logic o_kick_n = 1'b1
);
   logic [5:0] cnt_q = 6'h00;
   // pullup wins unless a party pulls low
   assign o_pin_n = (i_oe ? i_data_n : 1'b1) && i_button_n;
   always @(posedge i_clk) begin
      cnt_q <= #1 (cnt_q == 6'h27) ? 6'h00 : cnt_q + 6'h01;
      o_kick_n <= #1 !(i_kick_en && cnt_q == 6'h27);
   end
endmodule : sup_host

// >>> verif/supervisor_and_ram_gating_bench.sv
// supervisor_and_ram_gating_bench: self-checking bench for sup_top
// assumes shortened hold, debounce and watchdog counts
`timescale 1ns/1ps
module supervisor_and_ram_gating_bench;
   import sup_pkg::*;
   localparam int unsigned HC = 20, DC = 4, WC = 100;
   logic i_clk = 1'b0, i_arst_n = 1'b0, i_supply_ok = 1'b1;
   logic button_n = 1'b1, kick_en = 1'b1, ce = 1'b1;
   logic pin_n, kick_n, o_rst_pin_n, o_rst_pin_oe;
   sup_ram_in_t i_ram = 3'h0;
   sup_ram_out_t o_ram;
   int fail_count = 0, n_checks = 0, n;
   always #2.5 i_clk = !i_clk;
   sup_top #(.HOLD_CYCLES(HC), .DEB_CYCLES(DC), .WDOG_CYCLES(WC)) dut (.i_clk(i_clk),
      .i_arst_n(i_arst_n), .i_ce(ce), .i_supply_ok(i_supply_ok),
      .i_watchdog_kick_n(kick_n), .i_ram(i_ram), .i_rst_pin_n(pin_n),
      .o_rst_pin_n(o_rst_pin_n), .o_rst_pin_oe(o_rst_pin_oe), .o_ram(o_ram));
   sup_host host (.i_clk(i_clk), .i_oe(o_rst_pin_oe), .i_data_n(o_rst_pin_n),
      .i_button_n(button_n), .i_kick_en(kick_en), .o_pin_n(pin_n), .o_kick_n(kick_n));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   // inputs always move 1 ns after the edge
   task automatic tick(input int c);
      repeat (c) @(posedge i_clk);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wait_oe(input logic v, input int bound);
      n = 0;
      while (o_rst_pin_oe !== v && n < bound) begin
         tick(1);
         n++;
      end
      chk("oe wait", {1'b0, v}, {1'b0, o_rst_pin_oe});
      if (o_rst_pin_oe !== v) begin
         tally_and_finish();
      end
   endtask : wait_oe
   task automatic t_power_up();
      tick(HC - 2);
      chk("oe in hold", 2'h1, {1'b0, o_rst_pin_oe});
      chk("ram in hold", 2'h3, o_ram);
      wait_oe(1'b0, 10);
      tick(2);
      chk("ram word", 2'h0, o_ram);
      $display("power up done");
   endtask : t_power_up
   task automatic t_ram_table();
      for (int i = 0; i < 8; i++) begin
         i_ram = 3'(i);
         tick(2);
         chk("ram table", {i_ram[2] | i_ram[1], i_ram[2] | i_ram[0]}, o_ram);
      end
      // clock enable low must freeze the selects
      ce = 1'b0;
      i_ram = 3'h0;
      tick(2);
      chk("ram frozen", 2'h3, o_ram);
      ce = 1'b1;
      tick(2);
      chk("ram thawed", 2'h0, o_ram);
      $display("ram table done");
   endtask : t_ram_table
   task automatic t_supply_fail();
      i_ram = 3'h0;
      i_supply_ok = 1'b0;
      tick(2);
      chk("ram in fail", 2'h3, o_ram);
      chk("oe in fail", 2'h1, {1'b0, o_rst_pin_oe});
      i_supply_ok = 1'b1;
      tick(HC - 2);
      chk("oe after return", 2'h1, {1'b0, o_rst_pin_oe});
      chk("ram after return", 2'h3, o_ram);
      wait_oe(1'b0, 10);
      $display("supply fail done");
   endtask : t_supply_fail
   task automatic t_button();
      button_n = 1'b0;
      tick(DC + 2);
      button_n = 1'b1;
      wait_oe(1'b1, 5);
      tick(HC - 2);
      chk("button pulse", 2'h1, {1'b0, o_rst_pin_oe});
      chk("pin in pulse", 2'h0, {1'b0, pin_n});
      wait_oe(1'b0, 10);
      $display("button done");
   endtask : t_button
   task automatic t_watchdog();
      tick(3 * WC);
      chk("kicked", 2'h0, {1'b0, o_rst_pin_oe});
      kick_en = 1'b0;
      wait_oe(1'b1, WC + 50);
      chk("wdog late", 2'h1, {1'b0, n >= WC - 45});
      kick_en = 1'b1;
      wait_oe(1'b0, HC + 10);
      $display("watchdog done");
   endtask : t_watchdog
   initial begin
      tick(6);
      i_arst_n = 1'b1;
      t_power_up();
      t_ram_table();
      t_supply_fail();
      t_button();
      t_watchdog();
      tally_and_finish();
   end
endmodule : supervisor_and_ram_gating_bench
